// ==== bench/ext_parts_model.sv ====
// Model of boot ROM, peripheral chip, video source and strap resistors
`timescale 1ns/1ps
module ext_parts_model (
  // Clock and pins from the multiplexer
  input  wire logic        mclk,
  input  wire logic [63:0] memdata_o,
  input  wire logic [63:0] memdata_oe,
  input  wire logic [2:0]  vid_low_o,
  input  wire logic        vid_low_oe,
  input  wire logic        sel_o,
  input  wire logic        sel_oe,
  input  wire logic        stb_o,
  input  wire logic        stb_oe,
  input  wire logic        ce_n,
  // Bench controls
  input  wire logic        ext_video_n,
  input  wire logic [15:0] vid_src,
  input  wire logic        strap_sel,
  input  wire logic        strap_stb,
  // Pin levels back
  output logic [63:0]      memdata_i,
  output logic [2:0]       vid_low_i,
  output logic             sel_i,
  output logic             stb_i
);
  logic [63:0] pat_r = 64'h0000_0000_0000_0000;
  logic [63:0] far;
  logic [7:0]  rom_mem [logic [17:0]];
  logic [7:0]  per_mem [logic [16:0]];
  assign sel_i = sel_oe ? sel_o : strap_sel;
  assign stb_i = stb_oe ? stb_o : strap_stb;
  always @(posedge mclk) begin
    pat_r <= ~pat_r;
    if (!ce_n && memdata_oe[58] && !memdata_o[58]) rom_mem[memdata_o[49:32]] = memdata_o[57:50];
    if (!sel_i && !stb_i && memdata_oe[27] && !memdata_o[27])
      per_mem[memdata_o[16:0]] = memdata_o[25:18];
  end
  always @* begin
    far = pat_r;
    if (!ce_n && !stb_i && sel_i)
      far[57:50] = rom_mem.exists(memdata_o[49:32]) ? rom_mem[memdata_o[49:32]] : 8'hFF;
    if (!sel_i && !stb_i && !memdata_o[26])
      far[25:18] = per_mem.exists(memdata_o[16:0]) ? per_mem[memdata_o[16:0]] : 8'hFF;
    if (!ext_video_n) begin
      for (int i = 3; i < 16; i++) far[66 - i] = vid_src[i];
    end
    memdata_i = (memdata_oe & memdata_o) | (~memdata_oe & far);
    vid_low_i = vid_low_oe ? vid_low_o : (!ext_video_n ? vid_src[2:0] : pat_r[2:0]);
  end
endmodule : ext_parts_model

// ==== bench/shared_memory_pin_mux_sva.sv ====
// Checker of pin sharing, strobe selection and reset levels
`timescale 1ns/1ps
module pin_mux_chk (
  // Clock and resets
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        host_rst_n,
  // Requests
  input wire logic        rom_req,
  input wire logic        rom_write,
  input wire logic        rom_done,
  input wire logic [17:0] rom_addr,
  input wire logic [7:0]  rom_wdata,
  input wire logic        periph_req,
  input wire logic        periph_write,
  input wire logic [16:0] periph_addr,
  input wire logic [17:0] periph_ext_addr,
  input wire logic        periph_ext_en,
  input wire logic [7:0]  periph_wdata,
  input wire logic        dram_gnt,
  input wire logic        ext_video_n,
  // Pins
  input wire logic [63:0] memdata_o,
  input wire logic [63:0] memdata_oe,
  input wire logic        periph_select_n_o,
  input wire logic        periph_select_n_oe,
  input wire logic        periph_strobe_n_o,
  input wire logic        periph_strobe_n_oe,
  input wire logic        rom_ce_n,
  input wire logic        periph_reset_n,
  input wire logic        xcvr_en_n
);
  // ****
  // Helpers
  // ****
  logic [4:0] ev_cnt_r;
  wire        rom_rd = rom_req && !rom_write && !rom_ce_n && !rom_done;
  wire        stb_on = periph_strobe_n_oe && !periph_strobe_n_o;
  always_ff @(posedge mclk) begin
    if (!nrst || ext_video_n) ev_cnt_r <= 5'h00;
    else if (ev_cnt_r != 5'h1F) ev_cnt_r <= ev_cnt_r + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****
  // Properties
  // ****
  AST_STB_MUX: assert property (
    stb_on && periph_select_n_o |-> !rom_ce_n && rom_req && !rom_write)
    else $error("strobe pin low outside a ROM read");
  AST_ROM_ADR: assert property (
    !rom_ce_n && rom_req && !rom_done |-> &memdata_oe[49:32] && memdata_o[49:32] == rom_addr)
    else $error("ROM address not on shared pins");
  AST_ROM_WR: assert property (
    $fell(rom_ce_n) && rom_req && rom_write |-> ##[0:8] (memdata_oe[58] && !memdata_o[58]
    && &memdata_oe[57:50] && memdata_o[57:50] == rom_wdata))
    else $error("ROM write enable or data missing");
  AST_ROM_RD: assert property (
    rom_rd |-> memdata_oe[57:50] == 8'h00 && !(memdata_oe[58] && !memdata_o[58]))
    else $error("ROM read drives data or write enable");
  AST_P_RD: assert property (
    periph_req && memdata_oe[26] && !memdata_o[26] |-> !periph_write
    && memdata_o[16:0] == periph_addr && memdata_oe[25:18] == 8'h00)
    else $error("peripheral read pins wrong");
  AST_P_WR: assert property (
    periph_req && memdata_oe[27] && !memdata_o[27] |-> periph_write
    && memdata_o[25:18] == periph_wdata && memdata_o[26])
    else $error("peripheral write pins wrong");
  AST_P_EXT: assert property (
    periph_req && periph_ext_en && stb_on && !periph_select_n_o
    |-> memdata_o[49:32] == periph_ext_addr && rom_ce_n)
    else $error("extra peripheral address missing");
  AST_RST: assert property (disable iff (1'b0)
    !nrst |=> !periph_select_n_oe && !periph_strobe_n_oe && !periph_reset_n && !xcvr_en_n)
    else $error("reset levels wrong");
  AST_HRST: assert property (disable iff (1'b0)
    !host_rst_n [*8] |-> !periph_reset_n && !periph_strobe_n_oe)
    else $error("host reset not passed on");
  AST_VID_TRI: assert property (
    ev_cnt_r == 5'h1F |-> memdata_oe[63:51] == 13'h0000)
    else $error("video pins driven against external source");
  AST_OWNER: assert property (
    dram_gnt |-> rom_ce_n && periph_select_n_o)
    else $error("two owners of shared pins");
  COV_ROM_RD: cover property (rom_rd);
  COV_P_WR: cover property (periph_req && memdata_oe[27] && !memdata_o[27]);
  COV_VID: cover property (ev_cnt_r == 5'h1F);
endmodule : pin_mux_chk

bind shared_memory_pin_mux pin_mux_chk u_chk (.mclk, .nrst, .host_rst_n, .rom_req, .rom_write,
  .rom_done, .rom_addr, .rom_wdata, .periph_req, .periph_write, .periph_addr, .periph_ext_addr,
  .periph_ext_en, .periph_wdata, .dram_gnt, .ext_video_n, .memdata_o, .memdata_oe,
  .periph_select_n_o, .periph_select_n_oe, .periph_strobe_n_o, .periph_strobe_n_oe, .rom_ce_n,
  .periph_reset_n, .xcvr_en_n);

// ==== bench/tb_shared_memory_pin_mux.sv ====
// Self-checking bench of the shared-pin multiplexer
`timescale 1ns/1ps
module tb_shared_memory_pin_mux;
  logic        mclk = 1'b0;
  logic        nrst, host_rst_n, dram_req, dram_drive, rom_req, rom_write, periph_req;
  logic        periph_write, periph_ext_en, video_req, ext_video_n, strap_sel, strap_stb;
  logic        dram_gnt, rom_done, periph_done, video_ext_active, strap_select, strap_strobe;
  logic        vid_low_oe, xcvr_en_n, rom_ce_n, periph_reset_n;
  logic        periph_select_n_i, periph_select_n_o, periph_select_n_oe;
  logic        periph_strobe_n_i, periph_strobe_n_o, periph_strobe_n_oe;
  logic [63:0] dram_wdata, dram_rdata, memdata_i, memdata_o, memdata_oe;
  logic [17:0] rom_addr, periph_ext_addr, a;
  logic [16:0] periph_addr;
  logic [15:0] video_out, video_in, vid_src;
  logic [7:0]  rom_wdata, periph_wdata, rom_rdata, periph_rdata, d;
  logic [2:0]  vid_low_i, vid_low_o;
  logic [9:0]  e;
  logic [9:0]  exp_q[$];
  int          error_cnt = 0;
  int          total_checks = 0;
  shared_memory_pin_mux DUT (.mclk, .nrst, .dram_req, .dram_wdata, .dram_drive, .dram_gnt,
    .dram_rdata, .rom_req, .rom_write, .rom_addr, .rom_wdata, .rom_done, .rom_rdata, .periph_req,
    .periph_write, .periph_addr, .periph_ext_addr, .periph_ext_en, .periph_wdata, .periph_done,
    .periph_rdata, .video_req, .video_out, .video_in, .video_ext_active, .host_rst_n,
    .strap_select, .strap_strobe, .memdata_i, .memdata_o, .memdata_oe, .vid_low_i, .vid_low_o,
    .vid_low_oe, .ext_video_n, .xcvr_en_n, .periph_select_n_i, .periph_select_n_o,
    .periph_select_n_oe, .periph_strobe_n_i, .periph_strobe_n_o, .periph_strobe_n_oe,
    .rom_ce_n, .periph_reset_n);
  ext_parts_model u_far (.mclk, .memdata_o, .memdata_oe, .vid_low_o, .vid_low_oe,
    .sel_o(periph_select_n_o), .sel_oe(periph_select_n_oe), .stb_o(periph_strobe_n_o),
    .stb_oe(periph_strobe_n_oe), .ce_n(rom_ce_n), .ext_video_n, .vid_src, .strap_sel,
    .strap_stb, .memdata_i, .vid_low_i, .sel_i(periph_select_n_i), .stb_i(periph_strobe_n_i));
  always #12.5 mclk = ~mclk;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask : tick
  task automatic wait_for(input int k);
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((k == 0 ? rom_done : k == 1 ? periph_done : dram_gnt) !== 1'b1 && n < 300);
    if (n >= 300) chk(1'b0, "no completion");
    #2;
  endtask : wait_for
  task automatic rom_op(input logic wr, input logic [17:0] ad, input logic [7:0] dt);
    exp_q.push_back({~wr, 1'b0, dt});
    tick;
    rom_req = 1'b1;
    rom_write = wr;
    rom_addr = ad;
    rom_wdata = wr ? dt : 8'($urandom);
    wait_for(0);
    rom_req = 1'b0;
  endtask : rom_op
  task automatic per_op(input logic wr, input logic [16:0] ad, input logic [7:0] dt);
    exp_q.push_back({~wr, 1'b1, dt});
    tick;
    periph_req = 1'b1;
    periph_write = wr;
    periph_addr = ad;
    periph_wdata = wr ? dt : 8'($urandom);
    periph_ext_addr = 18'($urandom);
    periph_ext_en = 1'($urandom);
    wait_for(1);
    periph_req = 1'b0;
  endtask : per_op
  always @(posedge mclk) begin
    if (rom_done === 1'b1 || periph_done === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "completion without request");
      else begin
        e = exp_q.pop_front();
        chk(e[8] === periph_done, "completion of wrong port");
        if (e[9]) chk((e[8] ? periph_rdata : rom_rdata) === e[7:0], "read data");
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    chk(1'b0, "timeout");
    end_sim;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(89));
    {nrst, dram_req, dram_drive, rom_req, rom_write, periph_req, periph_write} = 7'h00;
    {periph_ext_en, video_req, host_rst_n, ext_video_n} = 4'h3;
    {dram_wdata, rom_addr, periph_ext_addr, periph_addr, video_out, vid_src} = 149'h0;
    {rom_wdata, periph_wdata} = 16'h0000;
    strap_sel = 1'($urandom);
    strap_stb = 1'($urandom);
    repeat (2) @(posedge mclk);
    #2 chk(periph_reset_n === 1'b0 && xcvr_en_n === 1'b0, "reset outputs");
    chk(periph_select_n_oe === 1'b0 && periph_strobe_n_oe === 1'b0, "pins not inputs");
    nrst = 1'b1;
    tick;
    tick;
    chk(strap_select === strap_sel && strap_strobe === strap_stb, "sampled straps");
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 18'h3FFFF : 18'($urandom);
      d = 8'($urandom);
      rom_op(1'b1, a, d);
      rom_op(1'b0, a, d);
      per_op(1'b1, a[16:0], ~d);
      per_op(1'b0, a[16:0], ~d);
    end
    tick;
    vid_src = 16'($urandom);
    ext_video_n = 1'b0;
    repeat (40) @(posedge mclk);
    #2 chk(video_in === vid_src && video_ext_active === 1'b1, "video from source");
    chk(memdata_oe[63:51] === 13'h0000 && vid_low_oe === 1'b0, "video pins driven");
    ext_video_n = 1'b1;
    video_out = 16'($urandom);
    video_req = 1'b1;
    repeat (10) @(posedge mclk);
    #2 chk(vid_low_o === video_out[2:0] && vid_low_oe === 1'b1, "video low bits");
    chk(xcvr_en_n === 1'b0, "transceiver enable");
    for (int i = 3; i < 16; i++) chk(memdata_o[66-i] === video_out[i], "video bit");
    video_req = 1'b0;
    repeat (4) tick;
    dram_wdata = {32'($urandom), 32'($urandom)};
    dram_drive = 1'b1;
    dram_req = 1'b1;
    wait_for(2);
    chk(memdata_o === dram_wdata && memdata_oe === 64'hFFFF_FFFF_FFFF_FFFF, "dram");
    chk(dram_rdata === dram_wdata, "dram read back");
    dram_drive = 1'b0;
    repeat (2) tick;
    chk(memdata_oe === 64'h0000_0000_0000_0000 && dram_gnt === 1'b1, "dram read drive");
    fork
      rom_op(1'b0, a, d);
      begin
        repeat (10) tick;
        dram_req = 1'b0;
      end
    join
    tick;
    host_rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #2 chk(periph_reset_n === 1'b0 && periph_strobe_n_oe === 1'b0, "host reset");
    host_rst_n = 1'b1;
    repeat (10) @(posedge mclk);
    #2 chk(periph_reset_n === 1'b1, "host reset release");
    rom_op(1'b0, a, d);
    repeat (4) tick;
    chk(exp_q.size() == 0, "unanswered requests");
    end_sim;
  end
endmodule : tb_shared_memory_pin_mux

// ==== hw/access_timer.sv ====
// Down counter timing strobe width and turnaround gaps.
`timescale 1ns/1ps
module access_timer (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Control
  input  wire logic       load,
  input  wire logic [3:0] count,
  output logic            busy
);
  logic [3:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Busy from the count only, so the load decision never feeds back on itself
  assign busy = (cnt_r != 4'h0);
endmodule : access_timer

// ==== hw/pin_mux_pkg.sv ====
// Constants and types shared by the shared-pin multiplexer design.
package pin_mux_pkg;

  // ****************************************************************
  // Pin field positions
  // ****************************************************************
  localparam int MEM_W       = 64;
  localparam int PADR_LO     = 0;
  localparam int PADR_W      = 17;
  localparam int PDAT_LO     = 18;
  localparam int PRD_BIT     = 26;
  localparam int PWR_BIT     = 27;
  localparam int RADR_LO     = 32;
  localparam int RADR_W      = 18;
  localparam int RDAT_LO     = 50;
  localparam int RWE_BIT     = 58;
  localparam int VID_HI      = 63;
  localparam int VID_SH_LO   = 3;
  localparam int VID_W       = 16;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int    MCLK_MHZ      = 40;
  localparam int    STROBE_NS     = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [3:0] TURN_CYC   = 4'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [MEM_W-1:0] MEM_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    OWN_IDLE  = 3'b000,
    OWN_DRAM  = 3'b001,
    OWN_ROM   = 3'b010,
    OWN_PERIPH = 3'b011,
    OWN_VIDEO = 3'b100,
    OWN_TURN  = 3'b101
  } owner_t;

endpackage : pin_mux_pkg

// ==== hw/pin_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge mclk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      level_out <= 1'b1;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule : pin_sync

// ==== hw/shared_memory_pin_mux.sv ====
// Multiplexer of ROM, peripheral and video functions onto frame-buffer data pins.
`timescale 1ns/1ps
module shared_memory_pin_mux (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // DRAM controller side
  input  wire logic        dram_req,
  input  wire logic [63:0] dram_wdata,
  input  wire logic        dram_drive,
  output logic             dram_gnt,
  output logic [63:0]      dram_rdata,
  // ROM access request
  input  wire logic        rom_req,
  input  wire logic        rom_write,
  input  wire logic [17:0] rom_addr,
  input  wire logic [7:0]  rom_wdata,
  output logic             rom_done,
  output logic [7:0]       rom_rdata,
  // Peripheral access request
  input  wire logic        periph_req,
  input  wire logic        periph_write,
  input  wire logic [16:0] periph_addr,
  input  wire logic [17:0] periph_ext_addr,
  input  wire logic        periph_ext_en,
  input  wire logic [7:0]  periph_wdata,
  output logic             periph_done,
  output logic [7:0]       periph_rdata,
  // Video port request
  input  wire logic        video_req,
  input  wire logic [15:0] video_out,
  output logic [15:0]      video_in,
  output logic             video_ext_active,
  // Host reset
  input  wire logic        host_rst_n,
  // Reset-time straps
  output logic             strap_select,
  output logic             strap_strobe,
  // Shared data pins
  input  wire logic [63:0] memdata_i,
  output logic [63:0]      memdata_o,
  output logic [63:0]      memdata_oe,
  // Dedicated video bits 0..2
  input  wire logic [2:0]  vid_low_i,
  output logic [2:0]       vid_low_o,
  output logic             vid_low_oe,
  // External video enable and transceiver enable
  input  wire logic        ext_video_n,
  output logic             xcvr_en_n,
  // Strobe, select, chip enable, reset
  input  wire logic        periph_select_n_i,
  output logic             periph_select_n_o,
  output logic             periph_select_n_oe,
  input  wire logic        periph_strobe_n_i,
  output logic             periph_strobe_n_o,
  output logic             periph_strobe_n_oe,
  output logic             rom_ce_n,
  output logic             periph_reset_n
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic ext_video_n_s;
  logic host_rst_n_s;

  pin_sync u_evid (
    .mclk      (mclk),
    .nrst      (nrst),
    .pin_in    (ext_video_n),
    .level_out (ext_video_n_s)
  );

  pin_sync u_hrst (
    .mclk      (mclk),
    .nrst      (nrst),
    .pin_in    (host_rst_n),
    .level_out (host_rst_n_s)
  );

  // Device in reset: either chip reset or host reset
  logic in_rst;
  assign in_rst = !nrst || !host_rst_n_s;

  // ****************************************************************
  // Ownership state
  // ****************************************************************
  pin_mux_pkg::owner_t own_r;
  pin_mux_pkg::owner_t own_nxt;
  logic                write_r;
  logic                timer_load;
  logic [3:0]          timer_count;
  logic                timer_busy;

  access_timer u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .load  (timer_load),
    .count (timer_count),
    .busy  (timer_busy)
  );

  // Grant one owner at a time, turnaround gap between owners
  always_comb begin
    own_nxt     = own_r;
    timer_load  = 1'b0;
    timer_count = pin_mux_pkg::STROBE_CYC;
    case (own_r)
      pin_mux_pkg::OWN_IDLE: begin
        if (!ext_video_n_s || video_req) begin
          own_nxt = pin_mux_pkg::OWN_VIDEO;
        end else if (dram_req) begin
          own_nxt = pin_mux_pkg::OWN_DRAM;
        end else if (rom_req) begin
          own_nxt    = pin_mux_pkg::OWN_ROM;
          timer_load = 1'b1;
        end else if (periph_req) begin
          own_nxt    = pin_mux_pkg::OWN_PERIPH;
          timer_load = 1'b1;
        end
      end
      pin_mux_pkg::OWN_DRAM: begin
        if (!dram_req) begin
          own_nxt     = pin_mux_pkg::OWN_TURN;
          timer_load  = 1'b1;
          timer_count = pin_mux_pkg::TURN_CYC;
        end
      end
      pin_mux_pkg::OWN_ROM, pin_mux_pkg::OWN_PERIPH: begin
        if (!timer_busy) begin
          own_nxt     = pin_mux_pkg::OWN_TURN;
          timer_load  = 1'b1;
          timer_count = pin_mux_pkg::TURN_CYC;
        end
      end
      pin_mux_pkg::OWN_VIDEO: begin
        if (ext_video_n_s && !video_req) begin
          own_nxt     = pin_mux_pkg::OWN_TURN;
          timer_load  = 1'b1;
          timer_count = pin_mux_pkg::TURN_CYC;
        end
      end
      pin_mux_pkg::OWN_TURN: begin
        if (!timer_busy) begin
          own_nxt = pin_mux_pkg::OWN_IDLE;
        end
      end
      default: begin
        own_nxt = pin_mux_pkg::OWN_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (in_rst) begin
      own_r <= pin_mux_pkg::OWN_IDLE;
    end else begin
      own_r <= own_nxt;
    end
  end

  // Latch direction at access start
  always_ff @(posedge mclk) begin
    if (in_rst) begin
      write_r <= 1'b0;
    end else if (own_r == pin_mux_pkg::OWN_IDLE) begin
      write_r <= (rom_req && !dram_req) ? rom_write : periph_write;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic is_rom;
  logic is_per;
  logic is_vid_out;
  assign is_rom     = (own_r == pin_mux_pkg::OWN_ROM);
  assign is_per     = (own_r == pin_mux_pkg::OWN_PERIPH);
  assign is_vid_out = (own_r == pin_mux_pkg::OWN_VIDEO) && ext_video_n_s;

  always_ff @(posedge mclk) begin
    if (in_rst) begin
      memdata_o  <= pin_mux_pkg::MEM_RST;
      memdata_oe <= pin_mux_pkg::MEM_RST;
      vid_low_o  <= 3'h0;
      vid_low_oe <= 1'b0;
    end else begin
      memdata_o  <= pin_mux_pkg::MEM_RST;
      memdata_oe <= pin_mux_pkg::MEM_RST;
      vid_low_o  <= video_out[2:0];
      vid_low_oe <= is_vid_out;
      if (own_nxt == pin_mux_pkg::OWN_DRAM) begin
        memdata_o  <= dram_wdata;
        memdata_oe <= {pin_mux_pkg::MEM_W{dram_drive}};
      end else if (own_nxt == pin_mux_pkg::OWN_ROM) begin
        memdata_o[pin_mux_pkg::RADR_LO +: pin_mux_pkg::RADR_W] <= rom_addr;
        memdata_oe[pin_mux_pkg::RADR_LO +: pin_mux_pkg::RADR_W] <= 18'h3FFFF;
        memdata_o[pin_mux_pkg::RDAT_LO +: 8] <= rom_wdata;
        memdata_oe[pin_mux_pkg::RDAT_LO +: 8] <= {8{rom_write}};
        memdata_o[pin_mux_pkg::RWE_BIT]  <= !(rom_write && timer_busy);
        memdata_oe[pin_mux_pkg::RWE_BIT] <= 1'b1;
      end else if (own_nxt == pin_mux_pkg::OWN_PERIPH) begin
        memdata_o[pin_mux_pkg::PADR_LO +: pin_mux_pkg::PADR_W] <= periph_addr;
        memdata_oe[pin_mux_pkg::PADR_LO +: pin_mux_pkg::PADR_W] <= 17'h1FFFF;
        memdata_o[pin_mux_pkg::PDAT_LO +: 8] <= periph_wdata;
        memdata_oe[pin_mux_pkg::PDAT_LO +: 8] <= {8{periph_write}};
        memdata_o[pin_mux_pkg::PRD_BIT]  <= periph_write;
        memdata_o[pin_mux_pkg::PWR_BIT]  <= !periph_write;
        memdata_oe[pin_mux_pkg::PRD_BIT] <= 1'b1;
        memdata_oe[pin_mux_pkg::PWR_BIT] <= 1'b1;
        if (periph_ext_en) begin
          memdata_o[pin_mux_pkg::RADR_LO +: pin_mux_pkg::RADR_W] <= periph_ext_addr;
          memdata_oe[pin_mux_pkg::RADR_LO +: pin_mux_pkg::RADR_W] <= 18'h3FFFF;
        end
      end else if (own_nxt == pin_mux_pkg::OWN_VIDEO && ext_video_n_s) begin
        for (int i = 0; i < pin_mux_pkg::VID_W - pin_mux_pkg::VID_SH_LO; i++) begin
          memdata_o[pin_mux_pkg::VID_HI - i]  <= video_out[pin_mux_pkg::VID_SH_LO + i];
          memdata_oe[pin_mux_pkg::VID_HI - i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Strobe, select and chip enable
  // ****************************************************************
  logic active_strobe;
  assign active_strobe = (is_rom || is_per) && timer_busy;

  always_ff @(posedge mclk) begin
    if (in_rst) begin
      periph_select_n_o  <= 1'b1;
      periph_select_n_oe <= 1'b0;
      periph_strobe_n_o  <= 1'b1;
      periph_strobe_n_oe <= 1'b0;
      rom_ce_n           <= 1'b1;
    end else begin
      periph_select_n_oe <= 1'b1;
      periph_strobe_n_oe <= 1'b1;
      periph_select_n_o  <= !is_per;
      // Strobe when selected, otherwise ROM output enable
      if (is_per) begin
        periph_strobe_n_o <= !active_strobe;
      end else begin
        periph_strobe_n_o <= !(is_rom && !write_r && timer_busy);
      end
      rom_ce_n <= !is_rom;
    end
  end

  // Straps sampled while reset held
  always_ff @(posedge mclk) begin
    if (in_rst) begin
      strap_select <= periph_select_n_i;
      strap_strobe <= periph_strobe_n_i;
    end
  end

  // ****************************************************************
  // Reset forwarding, transceiver enable and read data
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (in_rst) begin
      periph_reset_n   <= 1'b0;
      xcvr_en_n        <= 1'b0;
      video_ext_active <= 1'b0;
    end else begin
      periph_reset_n   <= 1'b1;
      xcvr_en_n        <= !ext_video_n_s;
      video_ext_active <= !ext_video_n_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (in_rst) begin
      rom_done     <= 1'b0;
      periph_done  <= 1'b0;
      rom_rdata    <= 8'h00;
      periph_rdata <= 8'h00;
      dram_gnt     <= 1'b0;
      dram_rdata   <= pin_mux_pkg::MEM_RST;
      video_in     <= 16'h0000;
    end else begin
      rom_done    <= is_rom && !timer_busy;
      periph_done <= is_per && !timer_busy;
      dram_gnt    <= (own_r == pin_mux_pkg::OWN_DRAM);
      dram_rdata  <= memdata_i;
      if (is_rom && !write_r && !timer_busy) begin
        rom_rdata <= memdata_i[pin_mux_pkg::RDAT_LO +: 8];
      end
      if (is_per && !write_r && !timer_busy) begin
        periph_rdata <= memdata_i[pin_mux_pkg::PDAT_LO +: 8];
      end
      video_in[2:0] <= vid_low_i;
      for (int j = 0; j < pin_mux_pkg::VID_W - pin_mux_pkg::VID_SH_LO; j++) begin
        video_in[pin_mux_pkg::VID_SH_LO + j] <= memdata_i[pin_mux_pkg::VID_HI - j];
      end
    end
  end

endmodule : shared_memory_pin_mux
